/* File: verilog/sac_pkg.sv */
// Shared constants and types of the converter control block.
// Assumes one clock domain; the analog converter sits outside.
package sac_pkg;
    localparam int unsigned SAC_RAW_W = 12;
    localparam int unsigned SAC_DATA_W = 16;
    localparam int unsigned SAC_SLOTS = 16;
    localparam int unsigned SAC_CH_W = 5;
    localparam int unsigned SAC_EXT_CH = 16;
    localparam logic [4:0] SAC_CH_TEMP = 5'h10;
    localparam logic [4:0] SAC_CH_VREF = 5'h11;
    localparam logic [1:0] SAC_RES_12 = 2'h0;
    localparam logic [1:0] SAC_RES_10 = 2'h1;
    localparam logic [1:0] SAC_RES_8 = 2'h2;
    localparam logic [1:0] SAC_RES_6 = 2'h3;
    localparam logic [7:0] SAC_CAL_CYCLES = 8'h20;
    localparam logic [3:0] SAC_SHIFT_MAX = 4'h8;
    localparam logic [15:0] SAC_DATA_RST = 16'h0000;
    localparam logic [11:0] SAC_FACTOR_RST = 12'h000;
    localparam logic [3:0] SAC_SLOT_RST = 4'h0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_STORE = 4'b1000
    } sac_seq_t;
endpackage

/* File: verilog/sac_cal.sv */
// Foreground calibration engine: timed run, then latches the offset factor.
// Assumes rst is asserted whenever the converter is switched off.
`timescale 1ns/1ps
module sac_cal
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic clear,
    input wire logic [11:0] offset_in,
    // Status
    output logic busy_r,
    output logic valid_r,
    output logic [11:0] factor_r
);
    localparam int CAL_SPAN = SAC_CAL_CYCLES;

    logic busy_nxt;
    logic valid_nxt;
    logic [11:0] factor_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        busy_nxt = busy_r;
        valid_nxt = valid_r;
        factor_nxt = factor_r;
        cnt_nxt = cnt_r;
        if (clear) begin
            valid_nxt = 1'b0;
            factor_nxt = SAC_FACTOR_RST;
        end
        if (busy_r) begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == SAC_CAL_CYCLES - 8'h01) begin
                busy_nxt = 1'b0;
                valid_nxt = 1'b1;
                factor_nxt = offset_in;
                cnt_nxt = 8'h00;
            end
        end else if (start) begin
            busy_nxt = 1'b1;
            cnt_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            valid_r <= 1'b0;
            factor_r <= SAC_FACTOR_RST;
            cnt_r <= 8'h00;
        end else begin
            busy_r <= busy_nxt;
            valid_r <= valid_nxt;
            factor_r <= factor_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    AST_CAL_SPAN: assert property (@(posedge clk) disable iff (rst)
        $rose(busy_r) |-> busy_r[*8] ##[1:CAL_SPAN] (!busy_r && valid_r))
        else $error("calibration run length wrong");
    AST_CAL_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (clear && !busy_r) |=> (!valid_r && factor_r == SAC_FACTOR_RST))
        else $error("calibration reset did not clear factor");
endmodule

/* File: verilog/sac_ovs.sv */
// Oversampling accumulator: sums 2 to 256 samples, shifts right, 16-bit result.
// Assumes in_valid pulses once per finished conversion.
`timescale 1ns/1ps
module sac_ovs
    import sac_pkg::*;
#(
    parameter int unsigned RAW_W = SAC_RAW_W
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Samples
    input wire logic clr,
    input wire logic in_valid,
    input wire logic [RAW_W-1:0] in_data,
    // Configuration
    input wire logic [2:0] ratio,
    input wire logic [3:0] shift,
    // Result
    output logic done_r,
    output logic [15:0] data_r
);
    localparam int unsigned ACC_W = RAW_W + 8;

    if (RAW_W < 6 || RAW_W > 16) begin : g_bad_width
        $error("sac_ovs: RAW_W out of range");
    end

    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic done_nxt;
    logic [15:0] data_nxt;

    always_comb begin
        logic [ACC_W-1:0] sum;
        logic [8:0] need;
        logic [3:0] sh;
        sum = acc_r + ACC_W'(in_data);
        need = 9'h002 << ratio;
        sh = (shift > SAC_SHIFT_MAX) ? SAC_SHIFT_MAX : shift;
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        data_nxt = data_r;
        if (clr) begin
            acc_nxt = '0;
            cnt_nxt = 9'h000;
        end else if (in_valid) begin
            if (cnt_r + 9'h001 == need) begin
                data_nxt = 16'(sum >> sh);
                done_nxt = 1'b1;
                acc_nxt = '0;
                cnt_nxt = 9'h000;
            end else begin
                acc_nxt = sum;
                cnt_nxt = cnt_r + 9'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= '0;
            cnt_r <= 9'h000;
            done_r <= 1'b0;
            data_r <= SAC_DATA_RST;
        end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            data_r <= data_nxt;
        end
    end

    AST_OVS_DONE: assert property (@(posedge clk) disable iff (rst)
        done_r |-> ($past(in_valid) && cnt_r == 9'h000))
        else $error("oversampler finished without a sample");
endmodule

/* File: verilog/sac_ctrl.sv */
// Converter control: enable, calibration, trigger, routine sequence, result.
// Assumes the analog converter and control bits share clk.
// Behaviour
// - Calibration start bit high until calibration ends; here calibration_busy_r is high instead
// - Calibration factor applied until converter powers off
// - Calibration reset clears the calibration factor
// - Converter off holds all logic in reset
// - Converter off powers down the analog part
// - Sequence up to 16 slots, 4-bit length
// - Eighteen channels: sixteen external, two internal
// - Resolution selectable: 12, 10, 8, 6 bits
// - Result stored right or left aligned
// - Oversampler 2x-256x, shift up to 8
// - Interrupts on end of sequence and watchdog
// - Single mode converts once per trigger
// - Continuous mode restarts without new trigger
// - Converter clock is the system clock, synchronous
// - Rising edge of external trigger starts sequence
`timescale 1ns/1ps
module sac_ctrl
    import sac_pkg::*;
#(
    parameter int unsigned SLOTS = SAC_SLOTS
)(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Enable and calibration control
    input wire logic converter_on,
    input wire logic calibration_start,
    input wire logic calibration_reset,
    // Sequence control
    input wire logic software_routine_start,
    input wire logic trigger_enable,
    input wire logic continuous_mode,
    input wire logic scan_mode,
    input wire logic [3:0] sequence_length,
    input wire logic [SLOTS*5-1:0] routine_sequence_select,
    // Data format
    input wire logic [1:0] resolution,
    input wire logic align_msb,
    input wire logic ovs_enable,
    input wire logic [2:0] ovs_ratio,
    input wire logic [3:0] ovs_shift,
    // Watchdog and flags
    input wire logic watchdog_enable,
    input wire logic [11:0] watchdog_high,
    input wire logic [11:0] watchdog_low,
    input wire logic eoc_clear,
    input wire logic watchdog_clear,
    input wire logic eoc_irq_enable,
    input wire logic watchdog_irq_enable,
    // External trigger pin
    input wire logic ext_trigger,
    // Analog converter
    input wire logic [11:0] adc_result,
    input wire logic adc_done,
    input wire logic [11:0] cal_offset,
    output logic adc_power_down_r,
    output logic [4:0] adc_channel_r,
    output logic adc_start_r,
    // Status
    output logic calibration_busy_r,
    output logic calibrated_r,
    output logic conv_busy_r,
    output logic eoc_flag_r,
    output logic watchdog_flag_r,
    output logic irq_eoc_r,
    output logic irq_watchdog_r,
    output logic [15:0] result_data_r,
    output logic result_strobe_r
);
    if (SLOTS < 1 || SLOTS > 16) begin : g_bad_slots
        $error("sac_ctrl: SLOTS must be 1 to 16");
    end

    // Converter off acts as a synchronous reset of the whole block
    logic rst_all;
    assign rst_all = sys_rst || !converter_on;

    logic [11:0] factor;
    logic ovs_done;
    logic [15:0] ovs_data;
    logic ovs_in;
    logic ovs_clr;
    logic cal_go;

    // Pin synchroniser
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic trig_lvl_r;
    logic trig_lvl_nxt;
    logic ext_rise;
    logic go;

    // Sequencer
    sac_seq_t state_r;
    sac_seq_t state_nxt;
    logic [3:0] slot_r;
    logic [3:0] slot_nxt;
    logic [3:0] last_slot;
    logic [11:0] sample_r;
    logic [11:0] sample_nxt;
    logic [11:0] corr_now;
    logic [4:0] slot_ch [SLOTS];
    logic [4:0] cur_ch;

    // Next values of the registered outputs
    logic adc_power_down_nxt;
    logic [4:0] adc_channel_nxt;
    logic adc_start_nxt;
    logic conv_busy_nxt;
    logic eoc_flag_nxt;
    logic watchdog_flag_nxt;
    logic irq_eoc_nxt;
    logic irq_watchdog_nxt;
    logic [15:0] result_data_nxt;
    logic result_strobe_nxt;

    // Calibration is refused while a sequence runs, so only calibration_reset can change the factor mid-sequence
    assign cal_go = calibration_start && !conv_busy_r;
    sac_cal u_cal (
        .clk(clk),
        .rst(rst_all),
        .start(cal_go),
        .clear(calibration_reset),
        .offset_in(cal_offset),
        .busy_r(calibration_busy_r),
        .valid_r(calibrated_r),
        .factor_r(factor)
    );

    // Offset correction saturates at zero rather than wrapping
    assign corr_now = (adc_result >= factor) ? adc_result - factor : 12'h000;

    assign ovs_in = adc_done && (state_r == ST_WAIT) && ovs_enable;
    assign ovs_clr = !ovs_enable || (state_r == ST_IDLE);
    sac_ovs #(
        .RAW_W(SAC_RAW_W)
    ) u_ovs (
        .clk(clk),
        .rst(rst_all),
        .clr(ovs_clr),
        .in_valid(ovs_in),
        .in_data(corr_now),
        .ratio(ovs_ratio),
        .shift(ovs_shift),
        .done_r(ovs_done),
        .data_r(ovs_data)
    );

    for (genvar g = 0; g < SLOTS; g++) begin : g_slot
        assign slot_ch[g] = routine_sequence_select[g*5 +: 5];
    end

    // Only the second and third stages are read; a change counts once they agree
    always_comb begin
        sync_nxt = {sync_r[1:0], ext_trigger};
        trig_lvl_nxt = trig_lvl_r;
        if (sync_r[1] == sync_r[2]) begin
            trig_lvl_nxt = sync_r[1];
        end
    end
    assign ext_rise = trigger_enable && (sync_r[1] == sync_r[2]) && sync_r[1] && !trig_lvl_r;
    assign go = (software_routine_start || ext_rise) && !calibration_busy_r && !calibration_start;

    // Slot codes above the last internal channel fall back to input 0
    always_comb begin
        last_slot = SAC_SLOT_RST;
        if (scan_mode) begin
            last_slot = (sequence_length > 4'(SLOTS - 1)) ? 4'(SLOTS - 1) : sequence_length;
        end
        cur_ch = slot_ch[slot_r];
        if (cur_ch > SAC_CH_VREF) begin
            cur_ch = 5'h00;
        end
    end

    always_comb begin
        logic [3:0] res_sh;
        logic [15:0] aligned;
        logic wd_hit;
        res_sh = {1'b0, resolution, 1'b0};
        aligned = {4'h0, sample_r >> res_sh};
        if (align_msb) begin
            aligned = aligned << (res_sh + 4'h4);
        end
        wd_hit = watchdog_enable && ((sample_r > watchdog_high) || (sample_r < watchdog_low));
        state_nxt = state_r;
        slot_nxt = slot_r;
        sample_nxt = sample_r;
        adc_power_down_nxt = 1'b0;
        adc_channel_nxt = adc_channel_r;
        adc_start_nxt = 1'b0;
        eoc_flag_nxt = eoc_flag_r;
        watchdog_flag_nxt = watchdog_flag_r;
        result_data_nxt = result_data_r;
        result_strobe_nxt = 1'b0;
        // A flag event in the same cycle as its clear wins
        if (eoc_clear) begin
            eoc_flag_nxt = 1'b0;
        end
        if (watchdog_clear) begin
            watchdog_flag_nxt = 1'b0;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (go) begin
                    slot_nxt = SAC_SLOT_RST;
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                adc_channel_nxt = cur_ch;
                adc_start_nxt = 1'b1;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (adc_done) begin
                    sample_nxt = corr_now;
                    state_nxt = ST_STORE;
                end
            end
            ST_STORE: begin
                if (ovs_enable && !ovs_done) begin
                    state_nxt = ST_START;
                end else begin
                    result_data_nxt = ovs_enable ? ovs_data : aligned;
                    result_strobe_nxt = 1'b1;
                    if (wd_hit) begin
                        watchdog_flag_nxt = 1'b1;
                    end
                    if (slot_r >= last_slot) begin
                        eoc_flag_nxt = 1'b1;
                        slot_nxt = SAC_SLOT_RST;
                        state_nxt = continuous_mode ? ST_START : ST_IDLE;
                    end else begin
                        slot_nxt = slot_r + 4'h1;
                        state_nxt = ST_START;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        conv_busy_nxt = (state_nxt != ST_IDLE);
        irq_eoc_nxt = eoc_flag_nxt && eoc_irq_enable;
        irq_watchdog_nxt = watchdog_flag_nxt && watchdog_irq_enable;
    end

    // Converter clock is clk itself; there is no second domain
    always_ff @(posedge clk) begin
        if (rst_all) begin
            sync_r <= 3'h0;
            trig_lvl_r <= 1'b0;
            state_r <= ST_IDLE;
            slot_r <= SAC_SLOT_RST;
            sample_r <= 12'h000;
            adc_power_down_r <= 1'b1;
            adc_channel_r <= 5'h00;
            adc_start_r <= 1'b0;
            conv_busy_r <= 1'b0;
            eoc_flag_r <= 1'b0;
            watchdog_flag_r <= 1'b0;
            irq_eoc_r <= 1'b0;
            irq_watchdog_r <= 1'b0;
            result_data_r <= SAC_DATA_RST;
            result_strobe_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            trig_lvl_r <= trig_lvl_nxt;
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            sample_r <= sample_nxt;
            adc_power_down_r <= adc_power_down_nxt;
            adc_channel_r <= adc_channel_nxt;
            adc_start_r <= adc_start_nxt;
            conv_busy_r <= conv_busy_nxt;
            eoc_flag_r <= eoc_flag_nxt;
            watchdog_flag_r <= watchdog_flag_nxt;
            irq_eoc_r <= irq_eoc_nxt;
            irq_watchdog_r <= irq_watchdog_nxt;
            result_data_r <= result_data_nxt;
            result_strobe_r <= result_strobe_nxt;
        end
    end

    sequence seq_launch;
        adc_start_r && (state_r == ST_WAIT);
    endsequence

    sequence seq_quiet;
        !adc_start_r;
    endsequence

    AST_LAUNCH: assert property (@(posedge clk) disable iff (rst_all)
        (state_r == ST_START) |=> seq_launch)
        else $error("conversion start not issued");
    AST_START_PULSE: assert property (@(posedge clk) disable iff (rst_all)
        seq_launch |=> seq_quiet)
        else $error("conversion start held too long");
    AST_CAL_BLOCKS: assert property (@(posedge clk) disable iff (rst_all)
        calibration_busy_r |-> !adc_start_r)
        else $error("conversion started during calibration");
    AST_OFF_POWER: assert property (@(posedge clk) disable iff (sys_rst)
        !converter_on |=> adc_power_down_r)
        else $error("converter off without power down");
    AST_CH_RANGE: assert property (@(posedge clk) disable iff (rst_all)
        adc_start_r |-> (adc_channel_r <= SAC_CH_VREF))
        else $error("channel code out of range");
endmodule

/* File: test/sac_adc_model.sv */
// Analog converter stand-in: answers each start with done after a set delay.
// Assumes it shares clk with the control block.
`timescale 1ns/1ps
module sac_adc_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic start,
    input wire logic power_down,
    input wire logic [11:0] sample,
    input wire logic [3:0] delay,
    // Answer
    output logic done,
    output logic [11:0] result
);
    int cnt = 0;
    initial begin
        done = 1'b0;
        result = 12'hA5A;
    end
    // Result toggles outside done so a stale value never passes
    always @(posedge clk) begin
        done <= 1'b0;
        result <= ~result;
        if (power_down) begin
            cnt <= 0;
        end else if (start) begin
            cnt <= delay + 1;
        end else if (cnt == 1) begin
            done <= 1'b1;
            result <= sample;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* File: test/sac_ctrl_test.sv */
// Self-checking bench of the converter control block.
// Assumes the converter model answers every start request.
`timescale 1ns/1ps
module sac_ctrl_test;
    import sac_pkg::*;
    logic clk = 0, sys_rst = 1, converter_on = 0, calibration_start = 0, calibration_reset = 0;
    logic software_routine_start = 0, trigger_enable = 1, continuous_mode = 0, scan_mode = 0, align_msb = 0;
    logic ovs_enable = 0, watchdog_enable = 0, eoc_clear = 0, watchdog_clear = 0, eoc_irq_enable = 1;
    logic watchdog_irq_enable = 0, ext_trigger = 0, adc_done, seen;
    logic [3:0] sequence_length = 4'h0, ovs_shift = 4'h0, dly = 4'h2;
    logic [79:0] routine_sequence_select = '0;
    logic [1:0] resolution = SAC_RES_12;
    logic [2:0] ovs_ratio = 3'h0;
    logic [11:0] watchdog_high = 12'hFFF, watchdog_low = 12'h000, adc_result, cal_offset = 12'h003, sample = 12'h000;
    logic adc_power_down_r, adc_start_r, calibration_busy_r, calibrated_r, conv_busy_r, eoc_flag_r;
    logic watchdog_flag_r, irq_eoc_r, irq_watchdog_r, result_strobe_r;
    logic [4:0] adc_channel_r;
    logic [15:0] result_data_r;
    logic [31:0] lfsr = 32'hC591;
    int errors = 0, checked = 0, hits = 0;

    sac_ctrl uut (.clk, .sys_rst, .converter_on, .calibration_start, .calibration_reset, .software_routine_start,
        .trigger_enable, .continuous_mode, .scan_mode, .sequence_length, .routine_sequence_select, .resolution,
        .align_msb, .ovs_enable, .ovs_ratio, .ovs_shift, .watchdog_enable, .watchdog_high, .watchdog_low,
        .eoc_clear, .watchdog_clear, .eoc_irq_enable, .watchdog_irq_enable, .ext_trigger, .adc_result, .adc_done,
        .cal_offset, .adc_power_down_r, .adc_channel_r, .adc_start_r, .calibration_busy_r, .calibrated_r,
        .conv_busy_r, .eoc_flag_r, .watchdog_flag_r, .irq_eoc_r, .irq_watchdog_r, .result_data_r, .result_strobe_r);
    sac_adc_model partner (.clk, .start(adc_start_r), .power_down(adc_power_down_r), .sample, .delay(dly),
        .done(adc_done), .result(adc_result));

    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [11:0] corr(input logic [11:0] s);
        return (s >= cal_offset) ? s - cal_offset : 12'h000;
    endfunction

    // Resolution drops low bits; left alignment puts the top bit at bit 15
    function automatic logic [15:0] exp_result(input logic [11:0] s, input logic [1:0] res, input logic msb);
        logic [15:0] v;
        v = {4'h0, corr(s) >> (2 * res)};
        if (msb) begin
            v = v << (4 + 2 * res);
        end
        return v;
    endfunction

    task automatic wait_strobe;
        seen = 0;
        repeat (80) if (!seen) begin
            @(negedge clk);
            seen = (result_strobe_r === 1'b1);
        end
    endtask

    task automatic count_strobes(input int span, output int count);
        count = 0;
        repeat (span) begin
            @(negedge clk);
            if (result_strobe_r === 1'b1) count++;
        end
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        check("power_down", 16'h1, adc_power_down_r);
        converter_on = 1;
        repeat (14) @(negedge clk);
        check("power_down", 16'h0, adc_power_down_r);
        calibration_start = 1;
        @(negedge clk);
        calibration_start = 0;
        software_routine_start = 1;
        @(negedge clk);
        software_routine_start = 0;
        check("cal_busy", 16'h1, calibration_busy_r);
        check("conv_busy", 16'h0, conv_busy_r);
        repeat (100) if (calibration_busy_r === 1'b1) @(negedge clk);
        check("cal_busy", 16'h0, calibration_busy_r);
        check("calibrated", 16'h1, calibrated_r);
        watchdog_enable = 1;
        watchdog_irq_enable = 1;
        watchdog_high = 12'hC00;
        watchdog_low = 12'h100;
        for (int i = 0; i < 12; i++) begin
            lfsr = next_rand(lfsr);
            sample = lfsr[11:0];
            align_msb = lfsr[12];
            dly = lfsr[16:13];
            resolution = lfsr[22:21];
            routine_sequence_select[4:0] = (i == 10) ? SAC_CH_TEMP : (i == 11) ? SAC_CH_VREF : {1'b0, lfsr[20:17]};
            if (i % 2 == 1) ext_trigger = 1;
            else software_routine_start = 1;
            repeat ((i % 2 == 1) ? 3 : 1) @(negedge clk);
            software_routine_start = 0;
            ext_trigger = 0;
            wait_strobe;
            check("strobe", 16'h1, seen);
            check("result", exp_result(sample, resolution, align_msb), result_data_r);
            check("channel", routine_sequence_select[4:0], adc_channel_r);
            check("irq_eoc", 16'h1, irq_eoc_r);
            check("watchdog", 16'((corr(sample) > watchdog_high) || (corr(sample) < watchdog_low)), watchdog_flag_r);
            check("irq_wd", 16'((corr(sample) > watchdog_high) || (corr(sample) < watchdog_low)), irq_watchdog_r);
            eoc_clear = 1;
            watchdog_clear = 1;
            repeat (3) @(negedge clk);
            eoc_clear = 0;
            watchdog_clear = 0;
            check("eoc", 16'h0, eoc_flag_r);
            check("conv_busy", 16'h0, conv_busy_r);
        end
        calibration_reset = 1;
        @(negedge clk);
        calibration_reset = 0;
        @(negedge clk);
        check("calibrated", 16'h0, calibrated_r);
        calibration_start = 1;
        @(negedge clk);
        calibration_start = 0;
        repeat (100) if (calibration_busy_r === 1'b1) @(negedge clk);
        check("calibrated", 16'h1, calibrated_r);
        watchdog_enable = 0;
        routine_sequence_select[14:5] = {5'h07, 5'h03};
        scan_mode = 1;
        sequence_length = 4'h2;
        continuous_mode = 1;
        dly = 4'h2;
        software_routine_start = 1;
        @(negedge clk);
        software_routine_start = 0;
        count_strobes(150, hits);
        check("continuous", 16'h1, 16'(hits >= 6));
        continuous_mode = 0;
        count_strobes(60, hits);
        check("conv_busy", 16'h0, conv_busy_r);
        software_routine_start = 1;
        @(negedge clk);
        software_routine_start = 0;
        count_strobes(100, hits);
        check("scan_slots", 16'h3, 16'(hits));
        check("channel", 16'h7, adc_channel_r);
        scan_mode = 0;
        ovs_enable = 1;
        ovs_ratio = 3'h1;
        ovs_shift = 4'h1;
        sample = 12'h123;
        software_routine_start = 1;
        @(negedge clk);
        software_routine_start = 0;
        wait_strobe;
        check("strobe", 16'h1, seen);
        check("ovs_result", {4'h0, corr(12'h123)} << 1, result_data_r);
        ovs_enable = 0;
        converter_on = 0;
        repeat (2) @(negedge clk);
        check("power_down", 16'h1, adc_power_down_r);
        complete_run;
    end

    // Whole run needs about 700 cycles
    initial begin
        #(20000 * 8);
        errors++;
        complete_run;
    end
endmodule
